/* include/liu_global_config_defines.vh */
/*
 * Constants for the global configuration register group of the line interface:
 * register addresses, field positions, reset values and detector thresholds.
 * Assumes an 8-bit parallel processor port and one 200 MHz system clock.
 */
// Overview of operation
// - extended enable raises the zero run that declares loss of signal to 4,096.
// - test bit set raises output_tristate_test for the output pins, the data bus stays driven; clear restores it.
// - source bit 0 uses per-channel termination bits, 1 uses shared hardware pin.
// - first master clock select 00/01/10/11 gives 1.544/3.088/6.176/12.352 MHz, default 00.
// - second master clock select 00/01/10/11 gives 2.048/4.096/8.192/16.384 MHz, default 00.
// - each violation counter is 16 bits, saturates, and raises overflow at saturation.
// - monitor select 0 reports violation activity, 1 reports counter overflow.
// - hardware reset clears every field to zero; each field writes and reads back.
`ifndef LIU_GLOBAL_CONFIG_DEFINES_VH
`define LIU_GLOBAL_CONFIG_DEFINES_VH

// ****************************************************************
// register addresses
// ****************************************************************
`define ADDR_LOS_TEST        8'hE1
`define ADDR_TERMINATION     8'hE2
`define ADDR_SLICER          8'hE3
`define ADDR_MCLK_SELECT     8'hE4
`define ADDR_VIOLATION_CTRL  8'hE5

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_EXT_ZEROS        1
`define BIT_TRISTATE_TEST    0
`define BIT_TERM_SOURCE      6
`define BIT_SLICER_HIGH      3
`define BIT_SLICER_LOW       2
`define FLD_MCLK_A_HI        7
`define FLD_MCLK_A_LO        6
`define FLD_MCLK_B_HI        5
`define FLD_MCLK_B_LO        4
`define BIT_MONITOR_SELECT   7

// ****************************************************************
// reset values and widths
// ****************************************************************
`define RESET_BYTE           8'h00
`define RESET_FIELD2         2'h0
`define CHANNELS             14
`define COUNT_MAX            16'hFFFF
`define COUNT_ONE            16'h0001
`define COUNT_ZERO           16'h0000
`define ZERO_RUN_NORMAL      13'h0020
`define ZERO_RUN_EXTENDED    13'h1000
`define ZERO_RUN_ONE         13'h0001
`define ZERO_RUN_NONE        13'h0000

`endif

/* logic/channel_violation_monitor.v */
/*
 * One channel's line code violation counter and digital loss-of-signal detector.
 * Assumes bit_tick, rx_zero, violation and counter_clear come from logic on clk.
 */
`timescale 1ns/1ps
`include "liu_global_config_defines.vh"

module channel_violation_monitor (
    input  wire        clk,              // system clock
    input  wire        rst_n,            // async reset, active low
    input  wire        bit_tick,         // one received bit this cycle
    input  wire        rx_zero,          // received bit is a zero
    input  wire        violation,        // code violation pulse
    input  wire        counter_clear,    // clear counter and overflow
    input  wire        extended_enable,  // long zero run threshold
    input  wire        monitor_select,   // status shows overflow when set
    output reg         status_reg,       // violation or overflow status
    output reg         overflow_reg,     // counter saturated
    output reg         loss_reg          // digital loss of signal
);

    reg  [15:0] count_reg;
    reg  [12:0] zero_run_reg;
    wire [12:0] threshold;

    assign threshold = extended_enable ? `ZERO_RUN_EXTENDED : `ZERO_RUN_NORMAL;

    // ****************************************************************
    // violation counter
    // ****************************************************************
    // a violation in the clear cycle still counts, so no event is lost
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg    <= `COUNT_ZERO;
            overflow_reg <= 1'b0;
        end else begin
            if (counter_clear) begin
                count_reg    <= violation ? `COUNT_ONE : `COUNT_ZERO;
                overflow_reg <= 1'b0;
            end else if (violation && count_reg != `COUNT_MAX) begin
                count_reg <= count_reg + `COUNT_ONE;
            end
            if (!counter_clear && count_reg == `COUNT_MAX) begin
                overflow_reg <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // zero run detector
    // ****************************************************************
    // run saturates at the threshold so a later threshold change is seen at once
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_run_reg <= `ZERO_RUN_NONE;
            loss_reg     <= 1'b0;
        end else begin
            if (bit_tick) begin
                if (!rx_zero) begin
                    zero_run_reg <= `ZERO_RUN_NONE;
                end else if (zero_run_reg < threshold) begin
                    zero_run_reg <= zero_run_reg + `ZERO_RUN_ONE;
                end
            end
            loss_reg <= (zero_run_reg >= threshold);
        end
    end

    // status selection
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= 1'b0;
        end else begin
            status_reg <= monitor_select ? overflow_reg : violation;
        end
    end

endmodule

/* logic/liu_global_config_registers.v */
/*
 * Global configuration registers of the line interface, reached over the
 * parallel processor port, and the per-channel logic they steer.
 * Assumes the processor pins are asynchronous to clk and that each strobe is
 * held for at least four clock periods; channel inputs are on clk.
 */
`timescale 1ns/1ps
`include "liu_global_config_defines.vh"

module liu_global_config_registers (
    input  wire        clk,                          // 200 MHz system clock
    input  wire        rst_n,                        // hardware reset, active low
    input  wire        cs_n,                         // chip select pin, active low
    input  wire        wr_n,                         // write strobe pin, active low
    input  wire        rd_n,                         // read strobe pin, active low
    input  wire [7:0]  addr,                         // register address pins
    input  wire [7:0]  data_in,                      // data bus input
    output reg  [7:0]  data_out,                     // data bus output
    output reg         data_oe,                      // data bus drive enable
    input  wire        rx_termination_pin,           // shared termination pin
    input  wire [13:0] channel_termination_bits,     // per-channel termination bits
    input  wire [13:0] bit_tick,                     // received bit strobes
    input  wire [13:0] rx_zero,                      // received bit is zero
    input  wire [13:0] line_code_violation,          // violation pulses
    input  wire        counter_clear,                // clear all violation counters
    output reg         extended_zero_count_enable,   // long zero run enabled
    output reg         output_tristate_test,         // outputs high impedance request, data bus stays live
    output reg         rx_termination_source,        // termination from pin
    output reg  [13:0] rx_termination_choice,        // termination in use
    output reg         slicer_level_high_bit,        // slicer level select high
    output reg         slicer_level_low_bit,         // slicer level select low
    output reg  [1:0]  master_clock_a_output,        // first master clock select
    output reg  [1:0]  master_clock_b_output,        // second master clock select
    output reg         violation_monitor_select,     // status shows overflow
    output wire [13:0] violation_status,             // per-channel status
    output wire [13:0] counter_overflow,             // per-channel overflow
    output wire [13:0] loss_of_signal                // per-channel digital loss
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    reg  [2:0]  strobe_s1_reg;
    reg  [2:0]  strobe_s2_reg;
    reg  [7:0]  addr_s1_reg;
    reg  [7:0]  addr_s2_reg;
    reg  [7:0]  data_s1_reg;
    reg  [7:0]  data_s2_reg;
    reg         term_pin_s1_reg;
    reg         term_pin_s2_reg;
    reg         write_active_reg;
    reg  [7:0]  write_addr_reg;
    reg  [7:0]  write_data_reg;
    reg  [7:0]  read_value;
    wire        write_now;
    wire        read_now;
    wire        write_done;

    // strobes and buses each pass two flops before any decode
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_s1_reg   <= 3'h7;
            strobe_s2_reg   <= 3'h7;
            addr_s1_reg     <= `RESET_BYTE;
            addr_s2_reg     <= `RESET_BYTE;
            data_s1_reg     <= `RESET_BYTE;
            data_s2_reg     <= `RESET_BYTE;
            term_pin_s1_reg <= 1'b0;
            term_pin_s2_reg <= 1'b0;
        end else begin
            strobe_s1_reg   <= {cs_n, wr_n, rd_n};
            strobe_s2_reg   <= strobe_s1_reg;
            addr_s1_reg     <= addr;
            addr_s2_reg     <= addr_s1_reg;
            data_s1_reg     <= data_in;
            data_s2_reg     <= data_s1_reg;
            term_pin_s1_reg <= rx_termination_pin;
            term_pin_s2_reg <= term_pin_s1_reg;
        end
    end

    assign write_now  = !strobe_s2_reg[2] && !strobe_s2_reg[1];
    assign read_now   = !strobe_s2_reg[2] && !strobe_s2_reg[0];
    assign write_done = write_active_reg && !write_now;

    // ****************************************************************
    // write capture
    // ****************************************************************
    // the last address and data seen while the strobe is low are committed
    // when it rises, so a bus still settling at the leading edge is harmless
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_active_reg <= 1'b0;
            write_addr_reg   <= `RESET_BYTE;
            write_data_reg   <= `RESET_BYTE;
        end else begin
            write_active_reg <= write_now;
            if (write_now) begin
                write_addr_reg <= addr_s2_reg;
                write_data_reg <= data_s2_reg;
            end
        end
    end

    // ****************************************************************
    // configuration fields
    // ****************************************************************
    // all fields clear on hardware reset and change the cycle after write ends
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extended_zero_count_enable <= 1'b0;
            output_tristate_test       <= 1'b0;
            rx_termination_source      <= 1'b0;
            slicer_level_high_bit      <= 1'b0;
            slicer_level_low_bit       <= 1'b0;
            master_clock_a_output      <= `RESET_FIELD2;
            master_clock_b_output      <= `RESET_FIELD2;
            violation_monitor_select   <= 1'b0;
        end else if (write_done) begin
            case (write_addr_reg)
                `ADDR_LOS_TEST: begin
                    extended_zero_count_enable <= write_data_reg[`BIT_EXT_ZEROS];
                    output_tristate_test       <= write_data_reg[`BIT_TRISTATE_TEST];
                end
                `ADDR_TERMINATION: begin
                    rx_termination_source <= write_data_reg[`BIT_TERM_SOURCE];
                end
                `ADDR_SLICER: begin
                    slicer_level_high_bit <= write_data_reg[`BIT_SLICER_HIGH];
                    slicer_level_low_bit  <= write_data_reg[`BIT_SLICER_LOW];
                end
                `ADDR_MCLK_SELECT: begin
                    master_clock_a_output <= write_data_reg[`FLD_MCLK_A_HI:`FLD_MCLK_A_LO];
                    master_clock_b_output <= write_data_reg[`FLD_MCLK_B_HI:`FLD_MCLK_B_LO];
                end
                `ADDR_VIOLATION_CTRL: begin
                    violation_monitor_select <= write_data_reg[`BIT_MONITOR_SELECT];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // read back
    // ****************************************************************
    // unused and reserved bits, and unmapped addresses, read as zero
    always @* begin
        read_value = `RESET_BYTE;
        case (addr_s2_reg)
            `ADDR_LOS_TEST: begin
                read_value[`BIT_EXT_ZEROS]     = extended_zero_count_enable;
                read_value[`BIT_TRISTATE_TEST] = output_tristate_test;
            end
            `ADDR_TERMINATION: begin
                read_value[`BIT_TERM_SOURCE] = rx_termination_source;
            end
            `ADDR_SLICER: begin
                read_value[`BIT_SLICER_HIGH] = slicer_level_high_bit;
                read_value[`BIT_SLICER_LOW]  = slicer_level_low_bit;
            end
            `ADDR_MCLK_SELECT: begin
                read_value[`FLD_MCLK_A_HI:`FLD_MCLK_A_LO] = master_clock_a_output;
                read_value[`FLD_MCLK_B_HI:`FLD_MCLK_B_LO] = master_clock_b_output;
            end
            `ADDR_VIOLATION_CTRL: begin
                read_value[`BIT_MONITOR_SELECT] = violation_monitor_select;
            end
            default: begin
                read_value = `RESET_BYTE;
            end
        endcase
    end

    // bus driver; the register port stays live in test mode so it can be left
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= `RESET_BYTE;
            data_oe  <= 1'b0;
        end else begin
            data_out <= read_value;
            data_oe  <= read_now && !write_now;
        end
    end

    // ****************************************************************
    // receive termination steering
    // ****************************************************************
    // one shared source bit switches every channel in the same cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_termination_choice <= 14'h0000;
        end else if (rx_termination_source) begin
            rx_termination_choice <= {`CHANNELS{term_pin_s2_reg}};
        end else begin
            rx_termination_choice <= channel_termination_bits;
        end
    end

    // ****************************************************************
    // channel monitors
    // ****************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < `CHANNELS; ch = ch + 1) begin : chan
            channel_violation_monitor monitor (
                .clk             (clk),
                .rst_n           (rst_n),
                .bit_tick        (bit_tick[ch]),
                .rx_zero         (rx_zero[ch]),
                .violation       (line_code_violation[ch]),
                .counter_clear   (counter_clear),
                .extended_enable (extended_zero_count_enable),
                .monitor_select  (violation_monitor_select),
                .status_reg      (violation_status[ch]),
                .overflow_reg    (counter_overflow[ch]),
                .loss_reg        (loss_of_signal[ch])
            );
        end
    endgenerate

endmodule

/* tb/liu_global_config_properties.sv */
/* Checker for the global configuration register group, at its ports only.
   Assumes it is bound to the top module and sees nothing but its ports. */
`timescale 1ns/1ps
module liu_global_config_properties (
    input logic        clk,                        // clock
    input logic        rst_n,                      // reset
    input logic        cs_n,                       // select
    input logic        wr_n,                       // write
    input logic        rd_n,                       // read
    input logic        data_oe,                    // bus drive
    input logic [13:0] channel_termination_bits,   // bits
    input logic [13:0] bit_tick,                   // ticks
    input logic [13:0] rx_zero,                    // zeros
    input logic [13:0] line_code_violation,        // pulses
    input logic        counter_clear,              // clear
    input logic        extended_zero_count_enable, // field
    input logic        rx_termination_source,      // field
    input logic [13:0] rx_termination_choice,      // in use
    input logic [1:0]  master_clock_a_output,      // field
    input logic [1:0]  master_clock_b_output,      // field
    input logic        violation_monitor_select,   // field
    input logic [13:0] violation_status,           // status
    input logic [13:0] counter_overflow,           // overflow
    input logic [13:0] loss_of_signal              // loss
);
    // ****************************************
    // sequences and properties
    // ****************************************
    wire [6:0] fields = {extended_zero_count_enable, rx_termination_source, master_clock_a_output,
                         master_clock_b_output, violation_monitor_select};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // five cycles cover the two-flop sync plus the output register
    sequence read_held; (!cs_n && !rd_n && wr_n) [*5]; endsequence
    sequence read_gone; (cs_n || rd_n || !wr_n) [*5]; endsequence
    sequence write_gone; (cs_n || wr_n) [*7]; endsequence
    a_oe_on_read: assert property (read_held |-> data_oe) else $error("bus not driven in read");
    a_oe_off_idle: assert property (read_gone |-> !data_oe) else $error("bus driven when idle");
    a_fields_hold: assert property (write_gone |-> $stable(fields)) else $error("field moved");
    a_reset_clears: assert property ($rose(rst_n) |-> fields == 7'h00) else $error("field not zero");
    a_status_tracks_viol: assert property (!violation_monitor_select |=>
        violation_status == $past(line_code_violation)) else $error("status not violation");
    a_status_shows_ovfl: assert property ((violation_monitor_select && $stable(counter_overflow)) [*2]
        |-> violation_status == counter_overflow) else $error("status not overflow");
    a_term_bits: assert property (!rx_termination_source |=>
        rx_termination_choice == $past(channel_termination_bits)) else $error("term not bits");
    a_term_pin: assert property (rx_termination_source |=>
        (&rx_termination_choice || !(|rx_termination_choice))) else $error("term not pin");
    a_clear_ovfl: assert property (counter_clear |=> counter_overflow == 14'h0000) else $error("ovfl kept");
    a_ovfl_sticky: assert property (!counter_clear |=>
        (counter_overflow & $past(counter_overflow)) == $past(counter_overflow)) else $error("ovfl lost");
    a_one_ends_loss: assert property (|(bit_tick & ~rx_zero) |-> ##3
        (loss_of_signal & $past(bit_tick & ~rx_zero, 3)) == 14'h0000) else $error("loss kept");
endmodule

bind liu_global_config_registers liu_global_config_properties liu_global_config_properties_i (
    .clk, .rst_n, .cs_n, .wr_n, .rd_n, .data_oe, .channel_termination_bits, .bit_tick, .rx_zero,
    .line_code_violation, .counter_clear, .extended_zero_count_enable, .rx_termination_source,
    .rx_termination_choice, .master_clock_a_output, .master_clock_b_output, .violation_monitor_select,
    .violation_status, .counter_overflow, .loss_of_signal
);

/* tb/host_port_model.sv */
/* Host processor model on the parallel register port.
   Assumes the bench calls write_reg and read_reg from falling-edge code. */
`timescale 1ns/1ps
module host_port_model (
    input  logic       clk,      // device clock
    input  logic [7:0] data_out, // device read data
    input  logic       data_oe,  // device drives bus
    output logic       cs_n,     // select
    output logic       wr_n,     // write strobe
    output logic       rd_n,     // read strobe
    output logic [7:0] addr,     // address
    output logic [7:0] data_in   // bus level
);
    // ****************************************
    // bus level and access tasks
    // ****************************************
    logic [7:0] drv_val = 8'h00;
    logic       drv_on = 1'b0;
    // a released bus shows the inverse, so a stale byte never passes
    assign data_in = data_oe ? data_out : (drv_on ? drv_val : ~drv_val);
    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        addr = 8'h00;
    end
    // strobe held five cycles, then idle long enough for the commit
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        drv_val = d;
        drv_on = 1'b1;
        cs_n = 1'b0;
        wr_n = 1'b0;
        repeat (5) @(negedge clk);
        cs_n = 1'b1;
        wr_n = 1'b1;
        drv_on = 1'b0;
        repeat (8) @(negedge clk);
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        addr = a;
        cs_n = 1'b0;
        rd_n = 1'b0;
        n = 0;
        while ((data_oe !== 1'b1 || n < 5) && n < 12) begin
            @(negedge clk);
            n++;
        end
        ok = (data_oe === 1'b1);
        d = data_out;
        cs_n = 1'b1;
        rd_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
endmodule

/* tb/liu_global_config_registers_bench.sv */
/* Self-checking bench for the global configuration register group.
   Assumes the host model drives the port; channel inputs change at negedge. */
`timescale 1ns/1ps
module liu_global_config_registers_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cs_n, wr_n, rd_n, data_oe, rd_ok, output_tristate_test, slicer_level_high_bit, slicer_level_low_bit;
    logic rx_termination_pin = 1'b0;
    logic counter_clear = 1'b0;
    logic extended_zero_count_enable, rx_termination_source, violation_monitor_select;
    logic [1:0]  master_clock_a_output, master_clock_b_output;
    logic [7:0]  addr, data_in, data_out, rd_val;
    logic [13:0] channel_termination_bits = 14'h0000;
    logic [13:0] bit_tick = 14'h0000;
    logic [13:0] rx_zero = 14'h0000;
    logic [13:0] line_code_violation = 14'h0000;
    logic [13:0] rx_termination_choice, violation_status, counter_overflow, loss_of_signal;
    logic [7:0]  msk [0:6] = '{8'h00, 8'h03, 8'h40, 8'h0C, 8'hF0, 8'h80, 8'h00};
    int          error_cnt = 0;
    int          num_checks = 0;
    int          cyc = 0;
    wire  [9:0]  fields = {extended_zero_count_enable, output_tristate_test, rx_termination_source,
                           slicer_level_high_bit, slicer_level_low_bit, master_clock_a_output,
                           master_clock_b_output, violation_monitor_select};
    liu_global_config_registers liu_global_config_registers_i (
        .clk, .rst_n, .cs_n, .wr_n, .rd_n, .addr, .data_in, .data_out, .data_oe, .rx_termination_pin,
        .channel_termination_bits, .bit_tick, .rx_zero, .line_code_violation, .counter_clear,
        .extended_zero_count_enable, .output_tristate_test, .rx_termination_source, .rx_termination_choice,
        .slicer_level_high_bit, .slicer_level_low_bit, .master_clock_a_output, .master_clock_b_output,
        .violation_monitor_select, .violation_status, .counter_overflow, .loss_of_signal);
    host_port_model host_port_model_i (.clk, .data_out, .data_oe, .cs_n, .wr_n, .rd_n, .addr, .data_in);
    // ****************************************
    // clock, timeout and checking tasks
    // ****************************************
    always #2.5 clk = ~clk;
    // run needs about 70k cycles, mostly the counter saturation
    always @(posedge clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host_port_model_i.read_reg(a, rd_val, rd_ok);
        check("read done", {15'h0000, rd_ok}, 16'h0001);
        check("read data", {8'h00, rd_val}, {8'h00, exp});
    endtask
    task automatic zeros(input int n);
        bit_tick = 14'h3FFF;
        rx_zero = 14'h3FFF;
        repeat (n) @(negedge clk);
        bit_tick = 14'h0000;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        check("fields after reset", {6'h00, fields}, 16'h0000);
        for (int i = 0; i < 7; i++) rd_chk(8'(8'hE0 + i), 8'h00);
        for (int i = 0; i < 7; i++) host_port_model_i.write_reg(8'(8'hE0 + i), 8'hFF);
        for (int i = 0; i < 7; i++) rd_chk(8'(8'hE0 + i), msk[i]);
        check("fields set", {6'h00, fields}, 16'h03FF);
        for (int i = 1; i < 6; i++) host_port_model_i.write_reg(8'(8'hE0 + i), 8'h00);
        check("fields clear", {6'h00, fields}, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            host_port_model_i.write_reg(8'hE4, {2'(k), 2'(3 - k), 4'h0});
            check("clock a", {14'h0000, master_clock_a_output}, 16'(k));
            check("clock b", {14'h0000, master_clock_b_output}, 16'(3 - k));
            rd_chk(8'hE4, {2'(k), 2'(3 - k), 4'h0});
        end
        // termination source: own bits, then the shared pin
        channel_termination_bits = 14'h2A5A;
        repeat (3) @(negedge clk);
        check("term bits", {2'h0, rx_termination_choice}, 16'h2A5A);
        host_port_model_i.write_reg(8'hE2, 8'h40);
        rx_termination_pin = 1'b1;
        repeat (5) @(negedge clk);
        check("term pin high", {2'h0, rx_termination_choice}, 16'h3FFF);
        rx_termination_pin = 1'b0;
        repeat (5) @(negedge clk);
        check("term pin low", {2'h0, rx_termination_choice}, 16'h0000);
        host_port_model_i.write_reg(8'hE2, 8'h00);
        check("term back", {2'h0, rx_termination_choice}, 16'h2A5A);
        // zero runs just below and past both thresholds
        zeros(31);
        check("loss normal below", {2'h0, loss_of_signal}, 16'h0000);
        zeros(9);
        check("loss normal", {2'h0, loss_of_signal}, 16'h3FFF);
        bit_tick = 14'h3FFF;
        rx_zero = 14'h0000;
        @(negedge clk);
        bit_tick = 14'h0000;
        repeat (4) @(negedge clk);
        check("loss ended", {2'h0, loss_of_signal}, 16'h0000);
        host_port_model_i.write_reg(8'hE1, 8'h02);
        zeros(4095);
        check("loss ext below", {2'h0, loss_of_signal}, 16'h0000);
        zeros(5);
        check("loss ext", {2'h0, loss_of_signal}, 16'h3FFF);
        host_port_model_i.write_reg(8'hE1, 8'h00);
        // violation activity, then saturation of the counter
        line_code_violation = 14'h0008;
        @(negedge clk);
        line_code_violation = 14'h0000;
        check("status pulse", {2'h0, violation_status}, 16'h0008);
        @(negedge clk);
        check("status idle", {2'h0, violation_status}, 16'h0000);
        counter_clear = 1'b1;
        @(negedge clk);
        counter_clear = 1'b0;
        line_code_violation = 14'h3FFF;
        repeat (65534) @(negedge clk);
        check("ovfl below", {2'h0, counter_overflow}, 16'h0000);
        repeat (3) @(negedge clk);
        line_code_violation = 14'h0000;
        check("ovfl set", {2'h0, counter_overflow}, 16'h3FFF);
        host_port_model_i.write_reg(8'hE5, 8'h80);
        check("status ovfl", {2'h0, violation_status}, 16'h3FFF);
        counter_clear = 1'b1;
        @(negedge clk);
        counter_clear = 1'b0;
        repeat (2) @(negedge clk);
        check("ovfl cleared", {2'h0, counter_overflow}, 16'h0000);
        check("status cleared", {2'h0, violation_status}, 16'h0000);
        close_out();
    end
endmodule
